/* File: rtl/nvm_power_gate.sv */
`timescale 1ns/100ps
`default_nettype none

module nvm_power_gate
    import nvm_prog_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic wr_i,
    input  wire logic latch_wdata_i,
    input  wire logic power_wdata_i,
    output logic      latch_o,
    output logic      power_o
);

    typedef struct packed
    {
        logic latch;
        logic power;
    } gate_state_t;

    gate_state_t st;
    gate_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (wr_i)
        begin
            next_st.latch = latch_wdata_i;
            next_st.power = power_wdata_i && st.latch && latch_wdata_i; // (RL2) (RL4) (RL7) (RL9)
        end
        if (!next_st.latch)
        begin
            next_st.power = 1'b0; // (RL3) (RL8)
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign latch_o = st.latch;
    assign power_o = st.power;

endmodule

`default_nettype wire

/* File: rtl/nvm_prog_pkg.sv */
package nvm_prog_pkg;

    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          MEM_ADDR_W     = 14;

    // Register offsets
    localparam logic [7:0]  EE_CTRL_OFFSET = 8'h1B;
    localparam logic [7:0]  EPROG_OFFSET   = 8'h1C;

    // Field positions, eeprom_programming_control
    localparam int          EE_POWER_BIT   = 0;
    localparam int          EE_RC_BIT      = 1;
    localparam int          EE_LATCH_BIT   = 2;
    localparam int          EE_ERASE_LO_BIT = 3;
    localparam int          EE_ERASE_HI_BIT = 4;
    localparam int          EE_PUMP_BIT    = 6;

    // Field positions, eprom_programming_control
    localparam int          EP_POWER_BIT   = 0;
    localparam int          EP_LATCH_BIT   = 1;

    // Reset values
    localparam logic [7:0]  EE_CTRL_RESET  = 8'h00;
    localparam logic [1:0]  EPROG_RESET    = 2'h0;
    localparam logic [7:0]  ERASED_BYTE    = 8'h00;

    // Memory windows
    localparam logic [13:0] EEPROM_BASE    = 14'h0300;
    localparam logic [13:0] EEPROM_LAST    = 14'h03EF;
    localparam logic [13:0] EPROM_BASE     = 14'h1000;
    localparam logic [13:0] EPROM_LAST     = 14'h2FBF;

    typedef enum logic [1:0]
    {
        MODE_PROGRAM,
        MODE_BYTE_ERASE,
        MODE_BLOCK_ERASE,
        MODE_BULK_ERASE
    } erase_mode_t;

endpackage

/* File: rtl/nvm_program_control.sv */
// Contract
// (RL1) EEPROM power bit connects programming power; here only while the pump bit (pump_en) is also set
// (RL2) EEPROM power set only with latch set
// (RL3) EEPROM power cleared while latch is zero
// (RL4) No single write sets latch and power
// (RL5) EPROM latch captures address and data
// (RL6) EPROM reads blocked while latch set
// (RL7) EPROM power needs latch already set
// (RL8) EPROM power cleared while latch is zero
// (RL9) No single write sets both EPROM bits
// (RL10) Software sequence programs one EPROM byte
// (RL11) Erased EPROM reads as all zeros
// (RL12) EEPROM latch captures writes, blocks reads
// (RL13) Erase select picks program or erase
// (RL14) Pump set with latch, gated by power; here the pump output follows pump_en and latch only
// (RL15) Latched address and data frozen under power
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module nvm_program_control
    import nvm_prog_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W,
    parameter int MW = MEM_ADDR_W
)
(
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    input  wire logic [AW-1:0] reg_addr_i,
    input  wire logic [DW-1:0] reg_wdata_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    output logic      [DW-1:0] reg_rdata_o,
    input  wire logic [MW-1:0] mem_addr_i,
    input  wire logic [DW-1:0] mem_wdata_i,
    input  wire logic          mem_wr_i,
    input  wire logic          mem_rd_i,
    input  wire logic [DW-1:0] eeprom_array_rdata_i,
    input  wire logic [DW-1:0] eprom_array_rdata_i,
    output logic      [DW-1:0] mem_rdata_o,
    output logic               mem_rd_blocked_o,
    output logic               eeprom_pump_on_o,
    output logic               eeprom_vpp_on_o,
    output logic               eeprom_rc_select_o,
    output logic      [1:0]    eeprom_erase_mode_o,
    output logic      [MW-1:0] eeprom_prog_addr_o,
    output logic      [DW-1:0] eeprom_prog_data_o,
    output logic               eprom_vpp_on_o,
    output logic      [MW-1:0] eprom_prog_addr_o,
    output logic      [DW-1:0] eprom_prog_data_o
);

    typedef struct packed
    {
        logic          pump_en;
        logic [1:0]    erase_sel;
        logic          rc_sel;
        logic [DW-1:0] rdata;
        logic [DW-1:0] mdata;
        logic          mblk;
        logic          ee_pump;
        logic          ee_vpp;
        logic          ep_vpp;
        logic [MW-1:0] ee_addr;
        logic [DW-1:0] ee_data;
        logic [MW-1:0] ep_addr;
        logic [DW-1:0] ep_data;
    } ctl_state_t;

    ctl_state_t st;
    ctl_state_t next_st;

    logic ee_latch;
    logic ee_power;
    logic ep_latch;
    logic ep_power;
    logic wr_ee_reg;
    logic wr_ep_reg;
    logic in_eeprom;
    logic in_eprom;

    function automatic logic in_range(input logic [MW-1:0] a, input logic [13:0] lo, input logic [13:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    assign wr_ee_reg = reg_wr_i && (reg_addr_i == EE_CTRL_OFFSET);
    assign wr_ep_reg = reg_wr_i && (reg_addr_i == EPROG_OFFSET);
    assign in_eeprom = in_range(mem_addr_i, EEPROM_BASE, EEPROM_LAST);
    assign in_eprom  = in_range(mem_addr_i, EPROM_BASE, EPROM_LAST);

    nvm_power_gate u_ee_gate
    (
        .clk_sys_i     (clk_sys_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (wr_ee_reg),
        .latch_wdata_i (reg_wdata_i[EE_LATCH_BIT]),
        .power_wdata_i (reg_wdata_i[EE_POWER_BIT]),
        .latch_o       (ee_latch),
        .power_o       (ee_power)
    );

    nvm_power_gate u_ep_gate
    (
        .clk_sys_i     (clk_sys_i),
        .rst_n_i       (rst_n_i),
        .wr_i          (wr_ep_reg),
        .latch_wdata_i (reg_wdata_i[EP_LATCH_BIT]),
        .power_wdata_i (reg_wdata_i[EP_POWER_BIT]),
        .latch_o       (ep_latch),
        .power_o       (ep_power)
    );

    always_comb
    begin
        next_st = st;
        next_st.rdata = '0;
        next_st.mdata = '0;
        next_st.mblk  = 1'b0;

        // Control bits of eeprom register
        if (wr_ee_reg)
        begin
            next_st.pump_en   = reg_wdata_i[EE_PUMP_BIT]; // (RL14)
            next_st.erase_sel = {reg_wdata_i[EE_ERASE_HI_BIT], reg_wdata_i[EE_ERASE_LO_BIT]}; // (RL13)
            next_st.rc_sel    = reg_wdata_i[EE_RC_BIT];
        end

        // Register read, data one cycle later
        if (reg_rd_i)
        begin
            if (reg_addr_i == EE_CTRL_OFFSET)
            begin
                next_st.rdata[EE_PUMP_BIT]     = st.pump_en;
                next_st.rdata[EE_ERASE_HI_BIT] = st.erase_sel[1];
                next_st.rdata[EE_ERASE_LO_BIT] = st.erase_sel[0];
                next_st.rdata[EE_LATCH_BIT]    = ee_latch;
                next_st.rdata[EE_RC_BIT]       = st.rc_sel;
                next_st.rdata[EE_POWER_BIT]    = ee_power;
            end
            else if (reg_addr_i == EPROG_OFFSET)
            begin
                next_st.rdata[EP_LATCH_BIT] = ep_latch;
                next_st.rdata[EP_POWER_BIT] = ep_power;
            end
        end

        // Address and data latches
        if (mem_wr_i && in_eeprom && ee_latch && !ee_power)
        begin
            next_st.ee_addr = mem_addr_i; // (RL12) (RL15)
            next_st.ee_data = mem_wdata_i;
        end
        if (mem_wr_i && in_eprom && ep_latch && !ep_power)
        begin
            next_st.ep_addr = mem_addr_i; // (RL5) (RL15)
            next_st.ep_data = mem_wdata_i;
        end

        // Array reads, blocked while latched
        if (mem_rd_i)
        begin
            if (in_eeprom)
            begin
                if (ee_latch)
                begin
                    next_st.mblk = 1'b1; // (RL12)
                end
                else
                begin
                    next_st.mdata = eeprom_array_rdata_i;
                end
            end
            else if (in_eprom)
            begin
                if (ep_latch)
                begin
                    next_st.mblk = 1'b1; // (RL6)
                end
                else
                begin
                    next_st.mdata = eprom_array_rdata_i; // (RL11)
                end
            end
        end

        // Power switches
        next_st.ee_pump = st.pump_en && ee_latch; // (RL14)
        next_st.ee_vpp  = ee_power && st.pump_en; // (RL1) (RL14)
        next_st.ep_vpp  = ep_power; // (RL7)
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_o         = st.rdata;
    assign mem_rdata_o         = st.mdata;
    assign mem_rd_blocked_o    = st.mblk;
    assign eeprom_pump_on_o    = st.ee_pump;
    assign eeprom_vpp_on_o     = st.ee_vpp;
    assign eeprom_rc_select_o  = st.rc_sel;
    assign eeprom_erase_mode_o = st.erase_sel;
    assign eeprom_prog_addr_o  = st.ee_addr;
    assign eeprom_prog_data_o  = st.ee_data;
    assign eprom_vpp_on_o      = st.ep_vpp;
    assign eprom_prog_addr_o   = st.ep_addr;
    assign eprom_prog_data_o   = st.ep_data;

endmodule

`default_nettype wire

/* File: test/nvm_program_control_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module nvm_program_control_monitor
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        mem_rd_i,
    input wire logic [7:0]  mem_rdata_o,
    input wire logic        mem_rd_blocked_o,
    input wire logic        eeprom_pump_on_o,
    input wire logic        eeprom_vpp_on_o,
    input wire logic [1:0]  eeprom_erase_mode_o,
    input wire logic [13:0] eprom_prog_addr_o,
    input wire logic        eprom_vpp_on_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic ee_w = reg_wr_i && reg_addr_i == 8'h1B;
    wire logic ep_w = reg_wr_i && reg_addr_i == 8'h1C;
    a_ee_vpp_gate: assert property (eeprom_vpp_on_o |-> eeprom_pump_on_o)
        else $error("eeprom vpp without pump");
    a_ee_power_clear: assert property (ee_w && !reg_wdata_i[2] |-> ##2 !eeprom_vpp_on_o)
        else $error("eeprom vpp kept after latch clear");
    a_ee_power_set: assert property ($rose(eeprom_vpp_on_o) |-> $past(ee_w, 2) && $past(reg_wdata_i[0], 2))
        else $error("eeprom vpp rose without power write");
    a_ep_power_clear: assert property (ep_w && !reg_wdata_i[1] |-> ##2 !eprom_vpp_on_o)
        else $error("eprom vpp kept after latch clear");
    a_ep_power_set: assert property ($rose(eprom_vpp_on_o) |-> $past(ep_w, 2) && $past(reg_wdata_i[0], 2))
        else $error("eprom vpp rose without power write");
    a_read_blocked: assert property (mem_rd_blocked_o |-> $past(mem_rd_i) && mem_rdata_o == 8'h00)
        else $error("blocked read wrong");
    a_ep_addr_freeze: assert property (eprom_vpp_on_o |-> $stable(eprom_prog_addr_o))
        else $error("eprom address moved under power");
    a_erase_select: assert property (ee_w |=> eeprom_erase_mode_o == $past(reg_wdata_i[4:3]))
        else $error("erase mode not written");
endmodule
bind nvm_program_control nvm_program_control_monitor mon (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .mem_rd_i, .mem_rdata_o, .mem_rd_blocked_o, .eeprom_pump_on_o, .eeprom_vpp_on_o,
    .eeprom_erase_mode_o, .eprom_prog_addr_o, .eprom_vpp_on_o);
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic [1:0] v;} row_t;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, mem_wr_i = 1'b0;
    logic        mem_rd_i = 1'b0, blk, pump, ee_vpp, ep_vpp, rc;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, mem_wdata_i = 8'h00, rdata, mdata, ee_d, ep_d;
    logic [7:0]  ee_arr = 8'hA5, ep_arr = 8'h3C;
    logic [13:0] mem_addr_i = 14'h0000, ee_a, ep_a;
    logic [1:0]  erase;
    int          n_errors = 0, total_checks = 0, i;
    row_t        rows [11] = '{'{8'h1B, 8'h05, 8'h04, 2'h0}, '{8'h1B, 8'h05, 8'h05, 2'h0},
        '{8'h1B, 8'h01, 8'h00, 2'h0}, '{8'h1B, 8'h5E, 8'h5E, 2'h0}, '{8'h1B, 8'hFF, 8'h5F, 2'h2},
        '{8'h1B, 8'h00, 8'h00, 2'h0}, '{8'h1C, 8'h03, 8'h02, 2'h0}, '{8'h1C, 8'h03, 8'h03, 2'h1},
        '{8'h1C, 8'h01, 8'h00, 2'h0}, '{8'h1C, 8'hFC, 8'h00, 2'h0}, '{8'h1D, 8'hFF, 8'h00, 2'h0}};
    always #4 clk_sys_i = ~clk_sys_i;
    nvm_program_control dut (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o(rdata), .mem_addr_i, .mem_wdata_i, .mem_wr_i, .mem_rd_i, .eeprom_array_rdata_i(ee_arr),
        .eprom_array_rdata_i(ep_arr), .mem_rdata_o(mdata), .mem_rd_blocked_o(blk), .eeprom_pump_on_o(pump),
        .eeprom_vpp_on_o(ee_vpp), .eeprom_rc_select_o(rc), .eeprom_erase_mode_o(erase),
        .eeprom_prog_addr_o(ee_a), .eeprom_prog_data_o(ee_d), .eprom_vpp_on_o(ep_vpp),
        .eprom_prog_addr_o(ep_a), .eprom_prog_data_o(ep_d));
    task results;
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input string n, input logic [13:0] e, input logic [13:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 check("reg_rdata_o", e, rdata);
    endtask
    task mw(input logic [13:0] a, input logic [7:0] d);
        mem_addr_i <= a;
        mem_wdata_i <= d;
        mem_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        mem_wr_i <= 1'b0;
        #1;
    endtask
    task mr(input logic [13:0] a, input logic [7:0] e, input logic b);
        mem_addr_i <= a;
        mem_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        mem_rd_i <= 1'b0;
        #1 check("mem_rdata_o", e, mdata);
        check("mem_rd_blocked_o", b, blk);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        results;
    end
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 11; i++)
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].r);
            check("vpp", rows[i].v, {ee_vpp, ep_vpp});
            if (i == 3)
                check("eeprom_rc_select_o", 1'b1, rc);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(8'h1B, 8'(8'h44 | (i << 3)));
            #1 check("eeprom_erase_mode_o", 14'(i), erase);
        end
        check("eeprom_rc_select_o", 1'b0, rc);
        mw(14'h0305, 8'h11);
        check("eeprom_prog_addr_o", 14'h0305, ee_a);
        check("eeprom_prog_data_o", 8'h11, ee_d);
        mr(14'h0305, 8'h00, 1'b1);
        check("eeprom_pump_on_o", 1'b1, pump);
        mr(14'h1500, ep_arr, 1'b0);
        wr(8'h1B, 8'h00);
        mr(14'h0305, ee_arr, 1'b0);
        mw(14'h1234, 8'h5A);
        check("eprom_prog_addr_o", 14'h0000, ep_a);
        wr(8'h1C, 8'h02);
        mw(14'h1234, 8'h5A);
        check("eprom_prog_addr_o", 14'h1234, ep_a);
        check("eprom_prog_data_o", 8'h5A, ep_d);
        mr(14'h1234, 8'h00, 1'b1);
        wr(8'h1C, 8'h03);
        mw(14'h1300, 8'h77);
        check("eprom_prog_addr_o", 14'h1234, ep_a);
        check("eprom_prog_data_o", 8'h5A, ep_d);
        check("eprom_vpp_on_o", 1'b1, ep_vpp);
        wr(8'h1C, 8'h00);
        mr(14'h1234, ep_arr, 1'b0);
        check("eprom_vpp_on_o", 1'b0, ep_vpp);
        wr(8'h1C, 8'h02);
        wr(8'h1B, 8'h5C);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(8'h1B, 8'h00);
        rd(8'h1C, 8'h00);
        check("eeprom_pump_on_o", 1'b0, pump);
        mr(14'h1234, ep_arr, 1'b0);
        results;
    end
endmodule
`default_nettype wire
